// ===== core/pllcc_if.sv
`timescale 1ns/1ns

// Lock timer request and status
interface pllcc_lock_if;
    logic start;
    logic short_lock;
    logic busy;
    modport ctrl  (output start, output short_lock, input busy);
    modport timer (input start, input short_lock, output busy);
endinterface

// Boot preset hand-off
interface pllcc_boot_if import pllcc_pkg::*;;
    logic              load;
    pllcc_pset_t       pset;
    logic [SET_W-1:0]  setting;
    modport ctrl (input load, input pset, input setting);
    modport src  (output load, output pset, output setting);
endinterface

// ===== core/pllcc_lock_timer.sv
`timescale 1ns/1ns

module pllcc_lock_timer import pllcc_pkg::*; (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   ref_tick,
    pllcc_lock_if.timer lk
);

    typedef struct packed {
        logic [LOCK_W-1:0] cnt;
        logic              busy;
    } pllcc_lt_t;

    pllcc_lt_t s_q;
    pllcc_lt_t s_d;

    // Count reference periods until lock
    always_comb begin
        s_d = s_q;
        if (lk.start) begin
            s_d.cnt  = lk.short_lock ? LOCK_SHORT : LOCK_FULL;
            s_d.busy = 1'b1;
        end else if (s_q.busy && ref_tick) begin
            s_d.cnt = s_q.cnt - 10'h001;
            if (s_q.cnt == 10'h001) begin
                s_d.busy = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lk.busy = s_q.busy;

endmodule // pllcc_lock_timer

// ===== core/pllcc_pkg.sv
package pllcc_pkg;

    // ****************************************************************
    // Structure
    // ****************************************************************
    localparam int NPLL   = 5;
    localparam int NF_W   = 8;
    localparam int NR_W   = 5;
    localparam int NO_W   = 3;
    localparam int SRC_W  = 3;
    localparam int DIV_W  = 6;
    localparam int SET_W  = 3;
    localparam int ADDR_W = 8;
    localparam int LOCK_W = 10;

    // Clock source indices
    localparam int PLL_SYS  = 0;
    localparam int PLL_AP   = 1;
    localparam int PLL_DISP = 2;
    localparam int PLL_IF   = 3;
    localparam int PLL_MEM  = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] PLL_CFG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] CLK_CFG_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] UPDATE_OFS   = 8'h40;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h44;

    // Field positions
    localparam int NF_LSB      = 0;
    localparam int NR_LSB      = 8;
    localparam int NO_LSB      = 16;
    localparam int SRC_LSB     = 0;
    localparam int DIV_LSB     = 8;
    localparam int UPD_CLK_LSB = 5;
    localparam int ST_BUSY_LSB = 5;
    localparam int ST_SET_LSB  = 10;

    // ****************************************************************
    // Timing, in reference clock periods
    // ****************************************************************
    localparam logic [LOCK_W-1:0] LOCK_FULL  = 10'h208;
    localparam logic [LOCK_W-1:0] LOCK_SHORT = 10'h00a;

    // ****************************************************************
    // Boot presets
    // ****************************************************************
    localparam logic [SET_W-1:0] SET_24   = 3'h0;
    localparam logic [SET_W-1:0] SET_13   = 3'h1;
    localparam logic [SET_W-1:0] SET_19_2 = 3'h2;
    localparam logic [SET_W-1:0] SET_27   = 3'h3;

    localparam logic [NF_W-1:0] NF_24   = 8'h1f;
    localparam logic [NF_W-1:0] NF_13   = 8'h3a;
    localparam logic [NF_W-1:0] NF_19_2 = 8'h27;
    localparam logic [NF_W-1:0] NF_27   = 8'h1b;
    localparam logic [NR_W-1:0] NR_PRE  = 5'h00;
    localparam logic [NO_W-1:0] NO_PRE  = 3'h4;

    typedef struct packed {
        logic [NF_W-1:0] nf;
        logic [NR_W-1:0] nr;
        logic [NO_W-1:0] no;
    } pllcc_pset_t;

endpackage

// ===== core/pllcc_preset.sv
`timescale 1ns/1ns

module pllcc_preset import pllcc_pkg::*; (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [SET_W-1:0] clk_setting,
    pllcc_boot_if.src             boot
);

    typedef struct packed {
        logic             done;
        logic             load;
        logic [SET_W-1:0] setting;
    } pllcc_pr_t;

    pllcc_pr_t   s_q;
    pllcc_pr_t   s_d;
    pllcc_pset_t pset;

    // Catch the strap once after reset release
    always_comb begin
        s_d      = s_q;
        s_d.load = 1'b0;
        if (!s_q.done) begin
            s_d.done    = 1'b1;
            s_d.load    = 1'b1;
            s_d.setting = clk_setting;
        end
    end

    // Preset table; unknown settings keep the 24 MHz values
    always_comb begin
        pset.nr = NR_PRE;
        pset.no = NO_PRE;
        case (s_q.setting)
            SET_13:   pset.nf = NF_13;
            SET_19_2: pset.nf = NF_19_2;
            SET_27:   pset.nf = NF_27;
            default:  pset.nf = NF_24;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign boot.load    = s_q.load;
    assign boot.pset    = pset;
    assign boot.setting = s_q.setting;

endmodule // pllcc_preset

// ===== core/pllcc_top.sv
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns

module pllcc_top import pllcc_pkg::*; (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    ref_tick,
    input  wire logic [SET_W-1:0]        clk_setting,
    output logic      [NPLL*NF_W-1:0]    pll_feedback_multiplier,
    output logic      [NPLL*NR_W-1:0]    pll_reference_divider,
    output logic      [NPLL*NO_W-1:0]    pll_output_divider,
    output logic      [NPLL-1:0]         pll_locked,
    output logic      [NPLL*SRC_W-1:0]   clk_source_sel,
    output logic      [NPLL*DIV_W-1:0]   clk_divider_value,
    output logic      [1:0]              clk_switch_to_ref
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NPLL-1:0][NF_W-1:0]  nf_stg;
        logic [NPLL-1:0][NR_W-1:0]  nr_stg;
        logic [NPLL-1:0][NO_W-1:0]  no_stg;
        logic [NPLL-1:0][NF_W-1:0]  nf_app;
        logic [NPLL-1:0][NR_W-1:0]  nr_app;
        logic [NPLL-1:0][NO_W-1:0]  no_app;
        logic [NPLL-1:0][SRC_W-1:0] src_stg;
        logic [NPLL-1:0][SRC_W-1:0] src_app;
        logic [NPLL-1:0][DIV_W-1:0] dv_stg;
        logic [NPLL-1:0][DIV_W-1:0] dv_app;
        logic [NPLL-1:0]            start;
        logic [NPLL-1:0]            short_lock;
        logic [NPLL-1:0]            locked;
        logic [1:0]                 to_ref;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } pllcc_top_t;

    pllcc_top_t     s_q;
    pllcc_top_t     s_d;
    logic [NPLL-1:0] busy;
    logic            access;
    logic            done;
    logic [31:0]     rd_word;
    logic            rd_ok;

    pllcc_lock_if lk_if[NPLL] ();
    pllcc_boot_if boot_if ();

    // ****************************************************************
    // Address decode helpers
    // ****************************************************************

    // True when the address falls in a five-word window
    function automatic logic in_win(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
        in_win = (a >= base) && (a < base + 8'h14) && (a[1:0] == 2'h0);
    endfunction

    // Word index inside a window
    function automatic logic [2:0] slot(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] d;
        d    = a - base;
        slot = d[4:2];
    endfunction

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************

    // Boot strap capture and preset table
    pllcc_preset u_preset (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_setting (clk_setting),
        .boot        (boot_if.src)
    );

    // One lock timer per PLL
    genvar gi;
    generate
        for (gi = 0; gi < NPLL; gi++) begin : g_lock
            assign lk_if[gi].start      = s_q.start[gi];
            assign lk_if[gi].short_lock = s_q.short_lock[gi];
            assign busy[gi]             = lk_if[gi].busy;

            pllcc_lock_timer u_lock (
                .pclk     (pclk),
                .presetn  (presetn),
                .ref_tick (ref_tick),
                .lk       (lk_if[gi].timer)
            );
        end
    endgenerate

    // ****************************************************************
    // APB read decode
    // ****************************************************************

    // Read word for the current address
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (in_win(paddr, PLL_CFG_BASE)) begin
            rd_word[NF_LSB +: NF_W] = s_q.nf_stg[slot(paddr, PLL_CFG_BASE)];
            rd_word[NR_LSB +: NR_W] = s_q.nr_stg[slot(paddr, PLL_CFG_BASE)];
            rd_word[NO_LSB +: NO_W] = s_q.no_stg[slot(paddr, PLL_CFG_BASE)];
        end else if (in_win(paddr, CLK_CFG_BASE)) begin
            rd_word[SRC_LSB +: SRC_W] =
                s_q.src_stg[slot(paddr, CLK_CFG_BASE)];
            rd_word[DIV_LSB +: DIV_W] =
                s_q.dv_stg[slot(paddr, CLK_CFG_BASE)];
        end else if (paddr == STATUS_OFS) begin
            rd_word[0 +: NPLL]           = s_q.locked;
            rd_word[ST_BUSY_LSB +: NPLL] = busy;
            rd_word[ST_SET_LSB +: SET_W] = boot_if.setting;
        end else if (paddr != UPDATE_OFS) begin
            rd_ok = 1'b0;
        end
    end

    // Access phase and completion edge; one wait state
    assign access = psel && penable && !s_q.pready;
    assign done   = psel && penable && s_q.pready;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d            = s_q;
        s_d.start      = '0;
        s_d.pready     = access;
        // Answer fields stand only in the cycle that pready does
        s_d.prdata     = 32'h0000_0000;
        s_d.pslverr    = 1'b0;
        if (access) begin
            s_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
            s_d.pslverr = !rd_ok;
        end

        // Boot preset loads both staged and applied copies
        if (boot_if.load) begin
            for (int i = 0; i < NPLL; i++) begin
                s_d.nf_stg[i]     = boot_if.pset.nf;
                s_d.nr_stg[i]     = boot_if.pset.nr;
                s_d.no_stg[i]     = boot_if.pset.no;
                s_d.nf_app[i]     = boot_if.pset.nf;
                s_d.nr_app[i]     = boot_if.pset.nr;
                s_d.no_app[i]     = boot_if.pset.no;
                s_d.start[i]      = 1'b1;
                s_d.short_lock[i] = 1'b0;
            end
        end

        // Register writes at the completion edge
        if (done && pwrite) begin
            if (in_win(paddr, PLL_CFG_BASE)) begin
                s_d.nf_stg[slot(paddr, PLL_CFG_BASE)] =
                    pwdata[NF_LSB +: NF_W];
                s_d.nr_stg[slot(paddr, PLL_CFG_BASE)] =
                    pwdata[NR_LSB +: NR_W];
                s_d.no_stg[slot(paddr, PLL_CFG_BASE)] =
                    pwdata[NO_LSB +: NO_W];
            end else if (in_win(paddr, CLK_CFG_BASE)) begin
                s_d.src_stg[slot(paddr, CLK_CFG_BASE)] =
                    pwdata[SRC_LSB +: SRC_W];
                s_d.dv_stg[slot(paddr, CLK_CFG_BASE)] =
                    pwdata[DIV_LSB +: DIV_W];
            end else if (paddr == UPDATE_OFS) begin
                for (int i = 0; i < NPLL; i++) begin
                    // PLL settings move to the running PLL
                    if (pwdata[i]) begin
                        s_d.nf_app[i]     = s_q.nf_stg[i];
                        s_d.nr_app[i]     = s_q.nr_stg[i];
                        s_d.no_app[i]     = s_q.no_stg[i];
                        s_d.start[i]      = 1'b1;
                        s_d.short_lock[i] =
                            (s_q.nf_stg[i] == s_q.nf_app[i]) &&
                            (s_q.nr_stg[i] == s_q.nr_app[i]);
                    end
                    // Source and divider move together
                    if (pwdata[UPD_CLK_LSB + i]) begin
                        s_d.src_app[i] = s_q.src_stg[i];
                        s_d.dv_app[i]  = s_q.dv_stg[i];
                    end
                end
            end
        end

        // Lock flags and glitch-free fallback while locking
        for (int i = 0; i < NPLL; i++) begin
            s_d.locked[i] = !busy[i] && !s_q.start[i];
        end
        for (int c = 0; c < 2; c++) begin
            s_d.to_ref[c] = (s_q.src_app[c] < 3'h5) &&
                            (busy[s_q.src_app[c]] ||
                             s_q.start[s_q.src_app[c]]);
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.nf_stg <= {NPLL{NF_24}};
            s_q.nf_app <= {NPLL{NF_24}};
            s_q.no_stg <= {NPLL{NO_PRE}};
            s_q.no_app <= {NPLL{NO_PRE}};
            s_q.src_stg <= {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
            s_q.src_app <= {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata                  = s_q.prdata;
    assign pready                  = s_q.pready;
    assign pslverr                 = s_q.pslverr;
    assign pll_feedback_multiplier = s_q.nf_app;
    assign pll_reference_divider   = s_q.nr_app;
    assign pll_output_divider      = s_q.no_app;
    assign pll_locked              = s_q.locked;
    assign clk_source_sel          = s_q.src_app;
    assign clk_divider_value       = s_q.dv_app;
    assign clk_switch_to_ref       = s_q.to_ref;

endmodule // pllcc_top

// ===== dv/pll_clock_configuration_bench.sv
`timescale 1ns/1ns
module pll_clock_configuration_bench import pllcc_pkg::*;;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic [ADDR_W-1:0]     paddr = 8'h00;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [31:0]           pwdata = 32'h0;
    logic                  ref_tick = 1'b0;
    logic [SET_W-1:0]      clk_setting = 3'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [NPLL*NF_W-1:0]  nf;
    logic [NPLL*NR_W-1:0]  nr;
    logic [NPLL*NO_W-1:0]  no;
    logic [NPLL-1:0]       pll_locked;
    logic [NPLL*SRC_W-1:0] src;
    logic [NPLL*DIV_W-1:0] dv;
    logic [1:0]            sw;
    logic [1:0]            tick_q = 2'h0;
    logic [31:0]           rdat;
    logic                  rerr;
    int                    bad_count = 0;
    int                    total_checks = 0;
    int                    cyc = 0;

    pllcc_top i_pllcc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_tick(ref_tick), .clk_setting(clk_setting),
        .pll_feedback_multiplier(nf), .pll_reference_divider(nr),
        .pll_output_divider(no), .pll_locked(pll_locked),
        .clk_source_sel(src), .clk_divider_value(dv),
        .clk_switch_to_ref(sw));

    // Clock, reference tick every third cycle, run limit
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
        ref_tick <= (tick_q == 2'h2);
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [SET_W-1:0] s);
        presetn <= 1'b0;
        clk_setting <= s;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    // Counts reference ticks from update until lock
    task automatic lock_ticks(input int i, output int n);
        n = 0;
        repeat (3) begin
            @(posedge pclk);
            n += int'(ref_tick);
        end
        check("locking", 32'(pll_locked[i]), 32'h0);
        if (i < 2) check("fallback", 32'(sw[i]), 32'h1);
        for (int k = 0; k < 9000 && pll_locked[i] !== 1'b1; k++) begin
            @(posedge pclk);
            n += int'(ref_tick);
        end
    endtask

    task automatic t_preset();
        logic [SET_W-1:0] s;
        logic [NF_W-1:0]  f;
        for (int j = 0; j < 5; j++) begin
            s = (j == 4) ? 3'h5 : 3'(j);
            f = (s == SET_13) ? NF_13 : (s == SET_19_2) ? NF_19_2 :
                (s == SET_27) ? NF_27 : NF_24;
            do_reset(s);
            for (int i = 0; i < NPLL; i++) begin
                check("mult", 32'(nf[i*NF_W+:NF_W]), 32'(f));
                check("rdiv", 32'(nr[i*NR_W+:NR_W]), 32'(NR_PRE));
                check("odiv", 32'(no[i*NO_W+:NO_W]), 32'(NO_PRE));
                check("src", 32'(src[i*SRC_W+:SRC_W]), 32'(i));
            end
            apb(STATUS_OFS, 1'b0, 32'h0);
            check("setting", 32'(rdat[12:10]), 32'(s));
            for (int k = 0; k < 9000 && pll_locked !== 5'h1f; k++) begin
                @(posedge pclk);
            end
        end
        $display("Test preset done");
    endtask

    task automatic t_pll();
        logic [31:0] cfg;
        int          n;
        for (int i = 0; i < NPLL; i++) begin
            cfg = (i % 2) ? 32'(i) : 32'h0007_1fff;
            apb(PLL_CFG_BASE + 8'(4 * i), 1'b1, cfg);
            check("held", 32'(nf[i*NF_W+:NF_W]), 32'(NF_24));
            apb(PLL_CFG_BASE + 8'(4 * i), 1'b0, 32'h0);
            check("staged", rdat, cfg);
            apb(UPDATE_OFS, 1'b1, 32'h1 << i);
            lock_ticks(i, n);
            check("full lock", 32'(n >= 520 && n <= 522), 32'h1);
            check("mult", 32'(nf[i*NF_W+:NF_W]), cfg[7:0]);
            check("rdiv", 32'(nr[i*NR_W+:NR_W]), cfg[12:8]);
            cfg = cfg ^ 32'h0003_0000;
            apb(PLL_CFG_BASE + 8'(4 * i), 1'b1, cfg);
            apb(UPDATE_OFS, 1'b1, 32'h1 << i);
            lock_ticks(i, n);
            check("short lock", 32'(n >= 10 && n <= 12), 32'h1);
            check("odiv", 32'(no[i*NO_W+:NO_W]), cfg[18:16]);
        end
        $display("Test pll done");
    endtask

    task automatic t_clk();
        for (int i = 0; i < NPLL; i++) begin
            apb(CLK_CFG_BASE + 8'(4 * i), 1'b1, 32'((63 - i) << 8 | 4 - i));
        end
        check("src held", 32'(src), 32'h4688);
        apb(UPDATE_OFS, 1'b1, 32'h3e0);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < NPLL; i++) begin
            check("src", 32'(src[i*SRC_W+:SRC_W]), 32'(4 - i));
            check("div", 32'(dv[i*DIV_W+:DIV_W]), 32'(63 - i));
        end
        $display("Test clock done");
    endtask

    task automatic t_bad();
        apb(8'h14, 1'b1, 32'h0000_00aa);
        check("wr err", 32'(rerr), 32'h1);
        apb(8'h80, 1'b0, 32'h0);
        check("rd err", 32'(rerr), 32'h1);
        check("rd data", rdat, 32'h0);
        apb(UPDATE_OFS, 1'b0, 32'h0);
        check("upd read", rdat, 32'h0);
        $display("Test refusal done");
    endtask

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        t_preset();
        t_pll();
        t_clk();
        t_bad();
        complete_run();
    end
endmodule // pll_clock_configuration_bench

bind pllcc_top pllcc_checker i_pllcc_checker (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_feedback_multiplier(pll_feedback_multiplier),
    .pll_reference_divider(pll_reference_divider),
    .pll_output_divider(pll_output_divider), .pll_locked(pll_locked),
    .clk_source_sel(clk_source_sel), .clk_divider_value(clk_divider_value),
    .clk_switch_to_ref(clk_switch_to_ref));

// ===== dv/pllcc_properties.sv
`timescale 1ns/1ns
module pllcc_checker import pllcc_pkg::*; (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [NPLL*NF_W-1:0]  pll_feedback_multiplier,
    input wire logic [NPLL*NR_W-1:0]  pll_reference_divider,
    input wire logic [NPLL*NO_W-1:0]  pll_output_divider,
    input wire logic [NPLL-1:0]       pll_locked,
    input wire logic [NPLL*SRC_W-1:0] clk_source_sel,
    input wire logic [NPLL*DIV_W-1:0] clk_divider_value,
    input wire logic [1:0]            clk_switch_to_ref
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic       upd_w;
    logic [1:0] age_q;

    // Completed write to the update register
    assign upd_w = psel && penable && pready && pwrite && paddr == UPDATE_OFS;

    // Cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // Properties
    // ****************************************************************
    AST_ONE_WAIT: assert property (
        psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_READY_PULSE: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready) else $error("pslverr without pready");
    AST_UNMAPPED: assert property (
        pready && paddr >= 8'h48 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_UPDATE_READS_ZERO: assert property (
        pready && !pwrite && paddr == UPDATE_OFS |-> prdata == 32'h0)
        else $error("update register read not zero");
    AST_HOLD_APPLIED: assert property (
        age_q == 2'h3 && !$past(upd_w) && !$past(upd_w, 2) |->
        $stable({pll_feedback_multiplier, pll_reference_divider,
                 pll_output_divider, clk_source_sel, clk_divider_value}))
        else $error("applied settings changed without update");
    AST_UPDATE_STARTS_LOCK: assert property (
        upd_w && pwdata[PLL_AP] |-> ##2 !pll_locked[PLL_AP])
        else $error("update did not start locking");
    AST_LOCK_MIN: assert property (
        $fell(pll_locked[PLL_SYS]) |-> !pll_locked[PLL_SYS] [*8])
        else $error("lock period too short");
    AST_FALLBACK_LOCKING: assert property (
        clk_switch_to_ref[0] |-> pll_locked != 5'h1f)
        else $error("fallback with all PLLs locked");
endmodule // pllcc_checker
